// ===== logic/iodc_diag_cfg.sv
// fault diagnostic scan configuration registers
`include "iodc_params.svh"

module iodc_diag_cfg (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rd_valid,
    // channel coupling from the input configuration
    input wire logic [1:0] i_ch_single_ended,
    input wire logic [1:0] i_ch_ac_coupled,
    // pin scan selects
    output logic o_in1_pos_scan,
    output logic o_in1_neg_scan,
    output logic o_in2_pos_scan,
    output logic o_in2_neg_scan,
    output logic o_out1_pos_scan,
    output logic o_out1_neg_scan,
    output logic o_out2_pos_scan,
    output logic o_out2_neg_scan,
    // short thresholds
    output logic [3:0] o_terminal_short_threshold,
    output logic [3:0] o_battery_short_threshold,
    output logic [8:0] o_term_mv,
    output logic o_term_mv_known,
    output logic [8:0] o_batt_mv,
    output logic o_batt_mv_known
);

    // ***************************************************************
    // reset release
    // ***************************************************************
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ***************************************************************
    // registers
    // ***************************************************************
    iodc_pkg::iodc_byte_t scan_en_r;
    iodc_pkg::iodc_byte_t thresh_r;
    logic wr_scan;
    logic wr_thresh;

    assign wr_scan = i_reg_wr && (i_reg_addr == `IODC_ADDR_SCAN_EN);
    assign wr_thresh = i_reg_wr && (i_reg_addr == `IODC_ADDR_THRESH);

    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            scan_en_r <= `IODC_RST_SCAN_EN;
        end else if (wr_scan) begin
            scan_en_r <= i_reg_wdata;
        end
    end

    // every code is kept as written, undocumented ones included
    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            thresh_r <= `IODC_RST_THRESH;
        end else if (wr_thresh) begin
            thresh_r <= i_reg_wdata;
        end
    end

    // ***************************************************************
    // read back
    // ***************************************************************
    // unmapped offsets read as zero; a read and write in one cycle
    // returns the old value
    iodc_pkg::iodc_byte_t rdata_nxt;

    always_comb begin
        rdata_nxt = 8'h00;
        case (i_reg_addr)
            `IODC_ADDR_SCAN_EN: rdata_nxt = scan_en_r;
            `IODC_ADDR_THRESH: rdata_nxt = thresh_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_reg_rdata <= 8'h00;
            o_reg_rd_valid <= 1'b0;
        end else begin
            o_reg_rd_valid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_nxt;
            end
        end
    end

    // ***************************************************************
    // pin scan selects
    // ***************************************************************
    // coupling inputs come from same-clock configuration logic
    logic [1:0] in_ok;
    logic [1:0] neg_ok;

    always_comb begin
        for (int k = 0; k < 2; k++) begin
            in_ok[k] = !i_ch_ac_coupled[k] ||
                scan_en_r[`IODC_BIT_INCL_AC];
            neg_ok[k] = !i_ch_single_ended[k] ||
                scan_en_r[`IODC_BIT_INCL_SE_NEG];
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_in1_pos_scan <= 1'b0;
            o_in1_neg_scan <= 1'b0;
            o_in2_pos_scan <= 1'b0;
            o_in2_neg_scan <= 1'b0;
        end else begin
            o_in1_pos_scan <= scan_en_r[`IODC_BIT_IN_ONE] && in_ok[0];
            o_in1_neg_scan <= scan_en_r[`IODC_BIT_IN_ONE] && in_ok[0] &&
                neg_ok[0];
            o_in2_pos_scan <= scan_en_r[`IODC_BIT_IN_TWO] && in_ok[1];
            o_in2_neg_scan <= scan_en_r[`IODC_BIT_IN_TWO] && in_ok[1] &&
                neg_ok[1];
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_out1_pos_scan <= 1'b0;
            o_out1_neg_scan <= 1'b0;
            o_out2_pos_scan <= 1'b0;
            o_out2_neg_scan <= 1'b0;
        end else begin
            o_out1_pos_scan <= scan_en_r[`IODC_BIT_OUT_ONE_POS];
            o_out1_neg_scan <= scan_en_r[`IODC_BIT_OUT_ONE_NEG];
            o_out2_pos_scan <= scan_en_r[`IODC_BIT_OUT_TWO_POS];
            o_out2_neg_scan <= scan_en_r[`IODC_BIT_OUT_TWO_NEG];
        end
    end

    // ***************************************************************
    // thresholds
    // ***************************************************************
    iodc_thr_if thr ();

    assign thr.term_code = thresh_r[`IODC_TERM_MSB:`IODC_TERM_LSB];
    assign thr.batt_code = thresh_r[`IODC_BATT_MSB:`IODC_BATT_LSB];

    iodc_thresh_map u_map (
        .thr(thr)
    );

    // reset values mirror the reset codes 3 and 7, both without a figure
    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_terminal_short_threshold <= 4'h3;
            o_battery_short_threshold <= 4'h7;
            o_term_mv <= `IODC_MV_0;
            o_term_mv_known <= 1'b0;
            o_batt_mv <= `IODC_MV_0;
            o_batt_mv_known <= 1'b0;
        end else begin
            o_terminal_short_threshold <= thr.term_code;
            o_battery_short_threshold <= thr.batt_code;
            o_term_mv <= thr.term_mv;
            o_term_mv_known <= thr.term_known;
            o_batt_mv <= thr.batt_mv;
            o_batt_mv_known <= thr.batt_known;
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    a_in_one_scan: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        !scan_en_r[7] |=> !o_in1_pos_scan && !o_in1_neg_scan)
        else $error("input one scanned while disabled");

    a_in_two_scan: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        scan_en_r[6] && !i_ch_ac_coupled[1] |=> o_in2_pos_scan)
        else $error("input two positive pin not scanned");

    a_se_neg_pin: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        scan_en_r[7] && !i_ch_ac_coupled[0] |=>
        o_in1_neg_scan == $past(scan_en_r[5] || !i_ch_single_ended[0]))
        else $error("single-ended negative pin selection wrong");

    a_ac_coupled: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        scan_en_r[7] && i_ch_ac_coupled[0] |=>
        o_in1_pos_scan == $past(scan_en_r[4]))
        else $error("ac-coupled pin selection wrong");

    a_out1p_scan: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        wr_scan |-> ##2 o_out1_pos_scan == $past(i_reg_wdata[3], 2))
        else $error("output one positive select lost");

    a_out1m_scan: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        wr_scan |-> ##2 o_out1_neg_scan == $past(i_reg_wdata[2], 2))
        else $error("output one negative select lost");

    a_out2p_scan: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        wr_scan |-> ##2 o_out2_pos_scan == $past(i_reg_wdata[1], 2))
        else $error("output two positive select lost");

    a_out2m_scan: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        wr_scan |-> ##2 o_out2_neg_scan == $past(i_reg_wdata[0], 2))
        else $error("output two negative select lost");

    a_term_low_codes: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        thresh_r[7:4] == 4'h1 |=> o_term_mv == 9'h01E && o_term_mv_known)
        else $error("terminal code 1 not 30 mV");

    a_term_high_codes: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        thresh_r[7:4] == 4'hE |=> o_term_mv == 9'h1A4 && o_term_mv_known)
        else $error("terminal code 14 not 420 mV");

    a_batt_low_codes: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        thresh_r[3:0] == 4'h2 |=> o_batt_mv == 9'h03C && o_batt_mv_known)
        else $error("battery code 2 not 60 mV");

    a_batt_high_codes: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        thresh_r[3:0] inside {[4'hA:4'hD]} |=> !o_batt_mv_known)
        else $error("battery configured code given a figure");

    a_code_passthru: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n_r)
        wr_thresh |-> ##2
        {o_terminal_short_threshold, o_battery_short_threshold} ==
        $past(i_reg_wdata, 2))
        else $error("threshold codes not passed unchanged");

endmodule

// ===== logic/iodc_params.svh
// offsets, field positions, reset values and threshold figures
`ifndef IODC_PARAMS_SVH
`define IODC_PARAMS_SVH

// ***************************************************************
// register offsets and reset values
// ***************************************************************
`define IODC_ADDR_SCAN_EN 8'h46
`define IODC_ADDR_THRESH 8'h47
`define IODC_RST_SCAN_EN 8'h00
`define IODC_RST_THRESH 8'h37

// ***************************************************************
// scan enable bit positions
// ***************************************************************
`define IODC_BIT_IN_ONE 7
`define IODC_BIT_IN_TWO 6
`define IODC_BIT_INCL_SE_NEG 5
`define IODC_BIT_INCL_AC 4
`define IODC_BIT_OUT_ONE_POS 3
`define IODC_BIT_OUT_ONE_NEG 2
`define IODC_BIT_OUT_TWO_POS 1
`define IODC_BIT_OUT_TWO_NEG 0

// ***************************************************************
// threshold fields
// ***************************************************************
`define IODC_TERM_MSB 7
`define IODC_TERM_LSB 4
`define IODC_BATT_MSB 3
`define IODC_BATT_LSB 0

// ***************************************************************
// threshold codes and their millivolt values
// ***************************************************************
`define IODC_CODE_0 4'h0
`define IODC_CODE_1 4'h1
`define IODC_CODE_2 4'h2
`define IODC_CODE_14 4'hE
`define IODC_CODE_15 4'hF
`define IODC_MV_0 9'h000
`define IODC_MV_30 9'h01E
`define IODC_MV_60 9'h03C
`define IODC_MV_420 9'h1A4
`define IODC_MV_450 9'h1C2

`endif

// ===== logic/iodc_pkg.sv
// types shared by the diagnostic configuration block
package iodc_pkg;
    typedef logic [3:0] iodc_code_t;
    typedef logic [8:0] iodc_mv_t;
    typedef logic [7:0] iodc_byte_t;
endpackage

// ===== logic/iodc_thr_if.sv
// threshold codes to the mapper and millivolt values back
interface iodc_thr_if;
    iodc_pkg::iodc_code_t term_code;
    iodc_pkg::iodc_code_t batt_code;
    iodc_pkg::iodc_mv_t term_mv;
    iodc_pkg::iodc_mv_t batt_mv;
    logic term_known;
    logic batt_known;

    modport mapper (
        input term_code,
        input batt_code,
        output term_mv,
        output batt_mv,
        output term_known,
        output batt_known
    );
    modport owner (
        output term_code,
        output batt_code,
        input term_mv,
        input batt_mv,
        input term_known,
        input batt_known
    );
endinterface

// ===== logic/iodc_thresh_map.sv
// maps 4-bit short threshold codes to millivolt figures
`include "iodc_params.svh"

module iodc_thresh_map (
    // codes in, figures out
    iodc_thr_if.mapper thr
);

    // ***************************************************************
    // code to millivolt decode
    // ***************************************************************
    // codes 3 to 13 carry no fixed figure here; the analog side owns
    // their meaning, so they come out as unknown with a zero figure
    function automatic logic [9:0] iodc_map(input iodc_pkg::iodc_code_t c);
        logic [9:0] r;
        r = {1'b0, `IODC_MV_0};
        case (c)
            `IODC_CODE_0: r = {1'b1, `IODC_MV_0};
            `IODC_CODE_1: r = {1'b1, `IODC_MV_30};
            `IODC_CODE_2: r = {1'b1, `IODC_MV_60};
            `IODC_CODE_14: r = {1'b1, `IODC_MV_420};
            `IODC_CODE_15: r = {1'b1, `IODC_MV_450};
            default: r = {1'b0, `IODC_MV_0};
        endcase
        return r;
    endfunction

    logic [9:0] term_map;
    logic [9:0] batt_map;

    assign term_map = iodc_map(thr.term_code);
    assign batt_map = iodc_map(thr.batt_code);
    assign thr.term_known = term_map[9];
    assign thr.term_mv = term_map[8:0];
    assign thr.batt_known = batt_map[9];
    assign thr.batt_mv = batt_map[8:0];

endmodule

// ===== verif/iodc_host_model.sv
// host controller model driving the register port of the device
module iodc_host_model (
    // clock
    input wire logic i_ref_clk,
    // register port toward the device
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    input wire logic [7:0] i_reg_rdata,
    input wire logic i_reg_rd_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
    end
    // ***************************************************************
    // access tasks
    // ***************************************************************
    // idle lines carry the inverse of the last value so stale data
    // can never pass for a fresh request
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_reg_wr <= 1'b1;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_ref_clk);
        o_reg_wr <= 1'b0;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
    endtask
    // read data is taken one cycle after the strobe edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic v);
        @(posedge i_ref_clk);
        o_reg_rd <= 1'b1;
        o_reg_addr <= a;
        @(posedge i_ref_clk);
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
        #1;
        d = i_reg_rdata;
        v = i_reg_rd_valid;
    endtask
endmodule

// ===== verif/input_output_diag_config_tb.sv
// self-checking bench for the diagnostic configuration registers
`include "iodc_params.svh"

module input_output_diag_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk, i_arst_n, wr, rd, rd_valid, tk, bk;
    logic [7:0] addr, wdata, rdata, scan;
    logic [1:0] se, ac;
    logic [3:0] term, batt;
    logic [8:0] tmv, bmv;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [7:0] en_tab [12] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
        8'h02, 8'h01, 8'hFF, 8'hE0, 8'hD0, 8'hC0};

    iodc_host_model iodc_host_model_inst (.i_ref_clk(i_ref_clk),
        .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .i_reg_rdata(rdata),
        .i_reg_rd_valid(rd_valid));
    iodc_diag_cfg iodc_diag_cfg_inst (.i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_rd_valid(rd_valid), .i_ch_single_ended(se),
        .i_ch_ac_coupled(ac), .o_in1_pos_scan(scan[7]),
        .o_in1_neg_scan(scan[6]), .o_in2_pos_scan(scan[5]),
        .o_in2_neg_scan(scan[4]), .o_out1_pos_scan(scan[3]),
        .o_out1_neg_scan(scan[2]), .o_out2_pos_scan(scan[1]),
        .o_out2_neg_scan(scan[0]), .o_terminal_short_threshold(term),
        .o_battery_short_threshold(batt), .o_term_mv(tmv),
        .o_term_mv_known(tk), .o_batt_mv(bmv), .o_batt_mv_known(bk));

    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    // ***************************************************************
    // helpers
    // ***************************************************************
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        iodc_host_model_inst.rd_reg(a, d, v);
        chk("read data", {8'h00, e}, {8'h00, d});
        chk("read valid", 16'h0001, {15'h0000, v});
    endtask
    // derived outputs land two edges after the write edge
    task automatic settle();
        repeat (2) @(posedge i_ref_clk);
        #1;
    endtask
    function automatic logic [7:0] exp_scan(input logic [7:0] en,
        input logic [1:0] s, input logic [1:0] c);
        logic p1, p2;
        p1 = en[7] & (~c[0] | en[4]);
        p2 = en[6] & (~c[1] | en[4]);
        return {p1, p1 & (~s[0] | en[5]), p2, p2 & (~s[1] | en[5]),
                en[3:0]};
    endfunction
    function automatic logic [15:0] exp_mv(input logic [3:0] c);
        case (c)
            `IODC_CODE_0: return {6'h00, 1'b1, `IODC_MV_0};
            `IODC_CODE_1: return {6'h00, 1'b1, `IODC_MV_30};
            `IODC_CODE_2: return {6'h00, 1'b1, `IODC_MV_60};
            `IODC_CODE_14: return {6'h00, 1'b1, `IODC_MV_420};
            `IODC_CODE_15: return {6'h00, 1'b1, `IODC_MV_450};
            default: return 16'h0000;
        endcase
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ***************************************************************
    // tests
    // ***************************************************************
    initial begin
        logic [3:0] cv;
        i_arst_n = 1'b0;
        se = 2'h0;
        ac = 2'h0;
        repeat (16) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        #1;
        chk("scan at reset", 16'h0000, {8'h00, scan});
        chk("codes at reset", 16'h0037, {8'h00, term, batt});
        rd_chk(`IODC_ADDR_SCAN_EN, `IODC_RST_SCAN_EN);
        rd_chk(`IODC_ADDR_THRESH, `IODC_RST_THRESH);
        $display("test reset done");
        // each of the twelve enable patterns in en_tab against every coupling mix
        foreach (en_tab[i]) begin
            iodc_host_model_inst.wr_reg(`IODC_ADDR_SCAN_EN, en_tab[i]);
            rd_chk(`IODC_ADDR_SCAN_EN, en_tab[i]);
            for (int c = 0; c < 16; c++) begin
                logic [7:0] es;
                cv = c[3:0];
                @(posedge i_ref_clk);
                se <= cv[1:0];
                ac <= cv[3:2];
                settle();
                es = exp_scan(en_tab[i], cv[1:0], cv[3:2]);
                chk("in selects", {12'h000, es[7:4]},
                    {12'h000, scan[7:4]});
                chk("out selects", {12'h000, es[3:0]},
                    {12'h000, scan[3:0]});
            end
        end
        $display("test scan enables done");
        // all sixteen codes in both nibbles, mirrored
        for (int c = 0; c < 16; c++) begin
            cv = c[3:0];
            iodc_host_model_inst.wr_reg(`IODC_ADDR_THRESH, {cv, ~cv});
            settle();
            chk("codes", {8'h00, cv, ~cv}, {8'h00, term, batt});
            chk("term mv", exp_mv(cv), {6'h00, tk, tmv});
            chk("batt mv", exp_mv(~cv), {6'h00, bk, bmv});
            rd_chk(`IODC_ADDR_THRESH, {cv, ~cv});
        end
        $display("test thresholds done");
        // unmapped offset: write ignored, read gives zero
        iodc_host_model_inst.wr_reg(8'h48, 8'h5A);
        rd_chk(8'h48, 8'h00);
        rd_chk(`IODC_ADDR_SCAN_EN, 8'hC0);
        rd_chk(`IODC_ADDR_THRESH, 8'hF0);
        $display("test unmapped offset done");
        end_sim();
    end
    // whole run is near 750 cycles, so sixteen times that is a hang
    initial begin
        #480000;
        n_mismatch++;
        end_sim();
    end
endmodule
